// *** scc_top.sv ***
// system clock control: register, source select, prescaler and gates
`timescale 1ns/1ps
module scc_top (
  // clock, reset, freeze
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [scc_pkg::APB_AW-1:0] paddr,
  input wire logic [scc_pkg::APB_DW-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [scc_pkg::APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // operating mode from the power controller
  input wire logic idle_mode,
  input wire logic power_down_mode,
  // oscillator ticks, one pclk pulse per source cycle
  input wire logic slow_rc_tick,
  input wire logic slow_xtal_tick,
  input wire logic fast_rc_tick,
  input wire logic fast_xtal_tick,
  // oscillator controls
  output logic slow_internal_oscillator_en,
  output logic slow_external_crystal_en,
  output logic fast_internal_oscillator_en,
  output logic fast_external_crystal_en,
  output logic xtal_pins_en,
  output logic xtal_high_gain,
  // system and peripheral clock enables
  output logic sys_clk_tick,
  output logic periph_clk_tick
);
  import scc_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0] clock_control_ff;
  logic [7:0] nxt_clock_control;
  logic [31:0] prdata_ff;
  logic perr_ff;
  logic sel_active_ff;
  logic [1:0] div_ff;
  logic [3:0] cnt_ff;
  logic sys_tick_ff;
  logic per_tick_ff;
  logic wr_hit;
  logic addr_hit;
  logic slow_tick;
  logic fast_tick;
  logic src_tick;
  logic at_boundary;
  logic fast_run;
  logic slow_rc_run;
  logic per_en;

  // limit of the source tick counter for a prescaler code
  function automatic logic [3:0] div_limit(input logic [1:0] code);
    logic [3:0] lim;
    lim = LIM_DIV1;
    unique case (code)
      PSC_DIV16: lim = LIM_DIV16;
      PSC_DIV4: lim = LIM_DIV4;
      PSC_DIV2: lim = LIM_DIV2;
      PSC_DIV1: lim = LIM_DIV1;
    endcase
    return lim;
  endfunction

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  // zero wait states while running, stalled while frozen
  assign addr_hit = (paddr == CLOCK_CONTROL_ADDR);
  assign pready = ce;
  assign wr_hit = psel & penable & pwrite & ce & addr_hit & pstrb[0];
  assign prdata = prdata_ff;
  assign pslverr = perr_ff;

  // read data and error captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0;
      perr_ff <= 1'b0;
    end else if (ce && psel && !penable) begin
      prdata_ff <= addr_hit ? {24'h0, clock_control_ff} : 32'h0;
      perr_ff <= !addr_hit;
    end
  end

  // ---------------------------------------------------------------
  // control register with mode locks
  // ---------------------------------------------------------------
  always_comb begin
    nxt_clock_control = clock_control_ff;
    if (wr_hit) begin
      nxt_clock_control[SLOW_RC_STOP_BIT] = pwdata[SLOW_RC_STOP_BIT];
      nxt_clock_control[PCK_STOP_BIT] = pwdata[PCK_STOP_BIT];
      nxt_clock_control[PSC_MSB:PSC_LSB] = pwdata[PSC_MSB:PSC_LSB];
      // slow type only in fast mode
      if (clock_control_ff[SEL_FAST_BIT]) begin
        nxt_clock_control[SLOW_TYPE_BIT] = pwdata[SLOW_TYPE_BIT];
      end
      // fast type only in slow mode
      // fast stop only in slow mode
      if (!clock_control_ff[SEL_FAST_BIT]) begin
        nxt_clock_control[FAST_TYPE_BIT] = pwdata[FAST_TYPE_BIT];
        nxt_clock_control[FCK_STOP_BIT] = pwdata[FCK_STOP_BIT];
      end
      // select only while fast clock runs
      if (!clock_control_ff[FCK_STOP_BIT]) begin
        nxt_clock_control[SEL_FAST_BIT] = pwdata[SEL_FAST_BIT];
      end
    end
  end

  // locked bits keep their value; reset value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_control_ff <= CLOCK_CONTROL_RST;
    end else if (ce) begin
      clock_control_ff <= nxt_clock_control;
    end
  end

  // ---------------------------------------------------------------
  // oscillator enables and crystal pins
  // ---------------------------------------------------------------
  // slow rc halts in power-down when asked
  assign slow_rc_run = !(clock_control_ff[SLOW_RC_STOP_BIT] &
                         power_down_mode);
  // fast clock halts in slow or idle when asked
  assign fast_run = !(clock_control_ff[FCK_STOP_BIT] &
                      (!sel_active_ff | idle_mode));
  // slow source type and crystal pins
  assign slow_internal_oscillator_en =
    !clock_control_ff[SLOW_TYPE_BIT] & slow_rc_run;
  assign slow_external_crystal_en = clock_control_ff[SLOW_TYPE_BIT];
  // fast source type and high gain
  assign fast_internal_oscillator_en =
    !clock_control_ff[FAST_TYPE_BIT] & fast_run;
  assign fast_external_crystal_en = clock_control_ff[FAST_TYPE_BIT] & fast_run;
  assign xtal_high_gain = clock_control_ff[FAST_TYPE_BIT];
  assign xtal_pins_en = clock_control_ff[SLOW_TYPE_BIT] |
                        clock_control_ff[FAST_TYPE_BIT];

  // ---------------------------------------------------------------
  // source select and prescaler
  // ---------------------------------------------------------------
  assign slow_tick = clock_control_ff[SLOW_TYPE_BIT] ? slow_xtal_tick :
                     (slow_rc_tick & slow_rc_run);
  assign fast_tick = (clock_control_ff[FAST_TYPE_BIT] ? fast_xtal_tick :
                      fast_rc_tick) & fast_run;
  assign src_tick = sel_active_ff ? fast_tick : slow_tick;
  assign at_boundary = src_tick && (cnt_ff >= div_limit(div_ff));

  // source and ratio change only at a full output period
  // pending ratio loads within one period of at most 16 ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_active_ff <= 1'b0;
      div_ff <= PSC_DIV1;
      cnt_ff <= 4'h0;
    end else if (ce && src_tick) begin
      if (at_boundary) begin
        cnt_ff <= 4'h0;
        div_ff <= clock_control_ff[PSC_MSB:PSC_LSB];
        sel_active_ff <= clock_control_ff[SEL_FAST_BIT];
      end else begin
        cnt_ff <= cnt_ff + 4'h1;
      end
    end
  end

  // one system tick per divided period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_tick_ff <= 1'b0;
    end else if (ce) begin
      sys_tick_ff <= at_boundary;
    end
  end

  assign per_en = !(clock_control_ff[PCK_STOP_BIT] & idle_mode);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_tick_ff <= 1'b0;
    end else if (ce) begin
      per_tick_ff <= at_boundary & per_en;
    end
  end

  assign sys_clk_tick = sys_tick_ff;
  assign periph_clk_tick = per_tick_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  logic [4:0] pend_ticks_ff;

  // source ticks seen while a new ratio waits to load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_ticks_ff <= 5'h0;
    end else if (ce) begin
      if (div_ff == clock_control_ff[PSC_MSB:PSC_LSB] || at_boundary) begin
        pend_ticks_ff <= 5'h0;
      end else if (src_tick) begin
        pend_ticks_ff <= pend_ticks_ff + 5'h1;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_slow_type_lock: assert property (
    wr_hit && !clock_control_ff[SEL_FAST_BIT] |=>
      $stable(clock_control_ff[SLOW_TYPE_BIT]))
    else $error("slow type changed in slow mode");

  a_fast_type_lock: assert property (
    wr_hit && clock_control_ff[SEL_FAST_BIT] |=>
      $stable(clock_control_ff[FAST_TYPE_BIT]))
    else $error("fast type changed in fast mode");

  a_fstop_lock: assert property (
    wr_hit && clock_control_ff[SEL_FAST_BIT] |=>
      $stable(clock_control_ff[FCK_STOP_BIT]))
    else $error("fast stop changed in fast mode");

  a_select_lock: assert property (
    wr_hit && clock_control_ff[FCK_STOP_BIT] |=>
      $stable(clock_control_ff[SEL_FAST_BIT]))
    else $error("select changed with fast stopped");

  a_write_takes: assert property (
    wr_hit |=> clock_control_ff[PSC_MSB:PSC_LSB] ==
      $past(pwdata[PSC_MSB:PSC_LSB]))
    else $error("prescaler write lost");

  a_slow_rc_halt: assert property (
    power_down_mode && clock_control_ff[SLOW_RC_STOP_BIT] |->
      !slow_internal_oscillator_en)
    else $error("slow rc runs in power-down");

  a_periph_gate: assert property (
    ce && idle_mode && clock_control_ff[PCK_STOP_BIT] |=> !periph_clk_tick)
    else $error("peripheral tick in idle");

  // fast clock halted in slow mode when fast stop is set
  a_fast_halt: assert property (
    clock_control_ff[FCK_STOP_BIT] && !sel_active_ff |->
      !fast_internal_oscillator_en && !fast_external_crystal_en)
    else $error("fast clock runs while stopped");

  // divide by one gives a tick per source tick
  a_div_one: assert property (
    ce && src_tick && div_ff == PSC_DIV1 |=> sys_clk_tick)
    else $error("missing tick at divide by one");

  // ratio loads within 16 source ticks
  a_psc_latency: assert property (
    pend_ticks_ff <= PSC_MAX_LATENCY)
    else $error("prescaler change too slow");

  // source and ratio change only with the counter back at zero
  a_count_bound: assert property (
    $changed(sel_active_ff) || $changed(div_ff) |-> cnt_ff == 4'h0)
    else $error("switch away from period boundary");

  a_xtal_pins: assert property (
    clock_control_ff[SLOW_TYPE_BIT] |-> xtal_pins_en)
    else $error("crystal pins not claimed");

  a_unmapped_err: assert property (
    ce && psel && !penable && !addr_hit |=> pslverr)
    else $error("unmapped access without error");

  // active source follows the select bit at a boundary
  a_select_load: assert property (
    ce && at_boundary |=>
      sel_active_ff == $past(clock_control_ff[SEL_FAST_BIT]))
    else $error("select not loaded at boundary");

  c_go_fast: cover property ($rose(sel_active_ff));
  c_go_slow: cover property ($fell(sel_active_ff));
  c_psc_change: cover property ($changed(div_ff));
  c_idle_gate: cover property (idle_mode && sys_clk_tick && !periph_clk_tick);
  c_locked_write: cover property (wr_hit && clock_control_ff[FCK_STOP_BIT]);
endmodule

// *** scc_pkg.sv ***
// constants for the system clock control block
// Summary of operation
// - The slow oscillator type may only change while the fast clock runs.
// - Slow type 0 picks the internal RC, 1 the external crystal pins.
// - The fast oscillator type may only change while the slow clock runs.
// - Fast type 0 picks the internal RC, 1 the crystal with high gain.
// - The slow RC stop bit halts that RC in power-down and resets to 1.
// - The peripheral stop bit gates UART and timer clocks in idle.
// - Fast stop halts the fast clock in slow or idle, writable in slow.
// - Clock select 0 is slow, 1 fast, changeable only with fast stop 0.
// - Prescaler codes 00, 01, 10, 11 divide by 16, 4, 2, 1; reset 11.
// - A new prescaler acts within 16 source clock cycles.
package scc_pkg;
  // ---------------------------------------------------------------
  // bus and register map
  // ---------------------------------------------------------------
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;
  localparam logic [7:0] CLOCK_CONTROL_ADDR = 8'hd8;
  localparam logic [7:0] CLOCK_CONTROL_RST = 8'h23;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SLOW_TYPE_BIT = 7;
  localparam int FAST_TYPE_BIT = 6;
  localparam int SLOW_RC_STOP_BIT = 5;
  localparam int PCK_STOP_BIT = 4;
  localparam int FCK_STOP_BIT = 3;
  localparam int SEL_FAST_BIT = 2;
  localparam int PSC_MSB = 1;
  localparam int PSC_LSB = 0;
  // ---------------------------------------------------------------
  // prescaler codes and counts
  // ---------------------------------------------------------------
  localparam logic [1:0] PSC_DIV16 = 2'h0;
  localparam logic [1:0] PSC_DIV4 = 2'h1;
  localparam logic [1:0] PSC_DIV2 = 2'h2;
  localparam logic [1:0] PSC_DIV1 = 2'h3;
  localparam logic [3:0] LIM_DIV16 = 4'hf;
  localparam logic [3:0] LIM_DIV4 = 4'h3;
  localparam logic [3:0] LIM_DIV2 = 4'h1;
  localparam logic [3:0] LIM_DIV1 = 4'h0;
  localparam logic [4:0] PSC_MAX_LATENCY = 5'h10;
endpackage

// *** scc_top_test.sv ***
// self-checking testbench for the system clock control block
`timescale 1ns/1ps
`define chk(got, exp) begin checks++; if ((got) !== (exp)) begin \
  err_count++; $display("unexpected at %0t: got %h exp %h", $time, \
  got, exp); end end
module scc_top_test;
  import scc_pkg::*;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic [APB_AW-1:0] paddr;
  logic [APB_DW-1:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic idle_mode, power_down_mode, tick, stick, er;
  logic [1:0] tdiv;
  logic slow_rc_en, slow_xt_en, fast_rc_en, fast_xt_en, pins_en, high_gain;
  logic sys_tick, per_tick;
  int err_count, checks, cycles, gap, run, sys_n, per_n, n0, s0;
  int div_tab[4] = '{16, 4, 2, 1};

  scc_top u_scc_top (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .idle_mode(idle_mode), .power_down_mode(power_down_mode),
    .slow_rc_tick(stick), .slow_xtal_tick(stick), .fast_rc_tick(tick),
    .fast_xtal_tick(tick), .slow_internal_oscillator_en(slow_rc_en),
    .slow_external_crystal_en(slow_xt_en),
    .fast_internal_oscillator_en(fast_rc_en),
    .fast_external_crystal_en(fast_xt_en), .xtal_pins_en(pins_en),
    .xtal_high_gain(high_gain), .sys_clk_tick(sys_tick),
    .periph_clk_tick(per_tick));

  // ----------------------------------------------------------------
  // clock, source ticks, tick gap meter and timeout
  // ----------------------------------------------------------------
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    tdiv <= tdiv + 2'h1;
    tick <= tdiv[0]; // fast source: one cycle every two pclk cycles
    stick <= (tdiv == 2'h3); // slow source: one cycle every four
    cycles <= cycles + 1;
    run <= sys_tick ? 1 : run + 1;
    if (sys_tick) gap <= run;
    if (sys_tick) sys_n <= sys_n + 1;
    if (per_tick) per_n <= per_n + 1;
    if (cycles == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  // one apb transfer: setup, then access until pready
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // hold the access until pready is seen high; the bench timeout bounds it
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // write the control register, read it back, compare
  task automatic wr_rd(input logic [7:0] d, input logic [7:0] e);
    apb(1'b1, CLOCK_CONTROL_ADDR, {24'h0, d});
    apb(1'b0, CLOCK_CONTROL_ADDR, 32'h0);
    `chk(rd, {24'h0, e})
  endtask

  task automatic test_reset();
    apb(1'b0, CLOCK_CONTROL_ADDR, 32'h0);
    `chk(rd, 32'h23)
    `chk(slow_rc_en, 1'b1)
    `chk({fast_rc_en, pins_en, high_gain}, 3'h4)
    power_down_mode <= 1'b1;
    @(posedge pclk);
    `chk(slow_rc_en, 1'b0)
    power_down_mode <= 1'b0;
  endtask

  task automatic test_locks();
    wr_rd(8'he3, 8'h63);
    `chk({high_gain, fast_xt_en, fast_rc_en, slow_xt_en}, 4'hc)
    wr_rd(8'h6b, 8'h6b);
    `chk(fast_xt_en, 1'b0)
    wr_rd(8'h6f, 8'h6b);
    wr_rd(8'h63, 8'h63);
    wr_rd(8'h67, 8'h67);
    wr_rd(8'ha7, 8'he7);
    wr_rd(8'hef, 8'he7);
    `chk({slow_xt_en, pins_en}, 2'h3)
  endtask

  // unmapped accesses flag an error and leave the register alone
  task automatic test_unmapped();
    apb(1'b1, 8'h00, 32'hff);
    `chk(er, 1'b1)
    apb(1'b0, 8'hd4, 32'h0);
    `chk({er, rd}, {1'b1, 32'h0})
    apb(1'b0, CLOCK_CONTROL_ADDR, 32'h0);
    `chk({er, rd}, {1'b0, 32'he7})
    wr_rd(8'he7, 8'he7);
  endtask

  // fast source ticks every 2 pclk, slow source every 4 pclk
  task automatic test_prescaler();
    for (int c = 0; c < 4; c++) begin
      wr_rd(8'he4 | 8'(c), 8'he4 | 8'(c));
      repeat (80) @(posedge pclk);
      `chk(gap, 2 * div_tab[c])
    end
    wr_rd(8'he3, 8'he3);
    repeat (80) @(posedge pclk);
    `chk(gap, 4)
  endtask

  task automatic test_periph();
    wr_rd(8'hf7, 8'hf7);
    idle_mode <= 1'b1;
    repeat (8) @(posedge pclk);
    n0 = per_n;
    s0 = sys_n;
    repeat (40) @(posedge pclk);
    `chk({per_n == n0, sys_n > s0}, 2'h3)
    idle_mode <= 1'b0;
    repeat (40) @(posedge pclk);
    `chk(per_n > n0, 1'b1)
    ce <= 1'b0;
    @(posedge pclk);
    `chk(pready, 1'b0)
    ce <= 1'b1;
  endtask

  task automatic report_and_stop();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 0;
    presetn = 0;
    ce = 1;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
    idle_mode = 0;
    power_down_mode = 0;
    tick = 0;
    stick = 0;
    tdiv = 2'h0;
    err_count = 0;
    checks = 0;
    cycles = 0;
    gap = 0;
    run = 0;
    sys_n = 0;
    per_n = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    test_locks();
    test_unmapped();
    test_prescaler();
    test_periph();
    report_and_stop();
  end
endmodule
